// file: logic/rro_core.sv
// Purpose: Executes no-op, interrupt return, literal return and rotate-left.
// Assumes: file data for the addressed register arrives the same cycle.
// Notes: Two-cycle returns assert busy during the flush cycle.
// Notes: The word fetched behind a return is dropped, not queued.
// Notes: Unknown words only step the PC; other opcodes live elsewhere.
// Notes on behaviour
// - Interrupt return pops the stack into the PC, sets global enable, two cycles, no flags.
// - Literal return loads W with the low 8 bits, ignores the don't-care bits, flags untouched.
// - Literal return also pops the stack top into the PC and takes two cycles.
// - Rotate-left moves old carry into bit 0 and old bit 7 into carry, changing only carry.
// - With destination bit 0 the rotated value goes to W and the file register is untouched.
// - With destination bit 1 the rotated value goes back to the file register in one cycle.
// - The rotate file address is a 7-bit field selecting registers 0 to 127.
`timescale 1ns/1ps
module rro_core
    import rro_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire rro_instr_t instr,
    input wire logic [RRO_PCW-1:0] stack_top_entry,
    input wire logic [RRO_DW-1:0] file_rdata,
    output logic [RRO_FAW-1:0] file_raddr,
    output logic busy,
    output logic stack_pop,
    output logic [RRO_PCW-1:0] pc,
    output logic [RRO_DW-1:0] w_reg,
    output logic carry,
    output logic global_irq_enable,
    output rro_fwrite_t file_wr
);
    rro_state_t state;
    rro_state_t next_state;
    logic take;
    // Pattern hits, all qualified by take
    logic is_no_operation;
    logic is_reti;
    logic is_retl;
    logic is_rlc;
    logic [RRO_DW-1:0] rot_val;
    // Derived controls
    logic ret_any;
    logic is_other;
    logic pc_step;
    logic rot_to_w;
    logic rot_to_file;
    // Next values of the architectural registers
    logic [RRO_PCW-1:0] next_pc;
    logic [RRO_DW-1:0] next_w_reg;
    logic next_carry;

    // Masked opcode compare, reused for every pattern
    // Mask bits at zero are the don't-care bits of the encoding
    function automatic logic op_match(
        input logic [13:0] w,
        input logic [13:0] v,
        input logic [13:0] m
    );
        op_match = ((w & m) == v);
    endfunction

    // Rotate left through carry; old carry fills bit 0
    // The old top bit leaves here and is caught by the carry register
    function automatic logic [RRO_DW-1:0] rot_left(
        input logic [RRO_DW-1:0] d,
        input logic c
    );
        rot_left = {d[RRO_DW-2:0], c};
    endfunction

    // Instructions are only taken in the execute state
    // The flush cycle and the dead cycle after reset both refuse words
    assign take = instr.valid && (state == RRO_ST_EXEC);

    // Pattern decode
    assign is_no_operation = take && op_match(instr.word, RRO_NO_OPERATION_VAL,
        RRO_NO_OPERATION_MASK);
    assign is_reti = take && op_match(instr.word, RRO_RETI_VAL, RRO_RETI_MASK);
    assign is_retl = take && op_match(instr.word, RRO_RETL_VAL, RRO_RETL_MASK);
    assign is_rlc = take && op_match(instr.word, RRO_RLC_VAL, RRO_RLC_MASK);

    // Any return pops the stack and flushes the word behind it
    assign ret_any = is_reti || is_retl;

    // Words matching no pattern here still step the PC
    assign is_other = take && !(is_no_operation || ret_any || is_rlc);

    // One-cycle words step the PC; returns load it instead
    assign pc_step = is_no_operation || is_rlc || is_other;

    // Rotate destination split on the d bit
    assign rot_to_w = is_rlc && !instr.word[RRO_DEST_BIT];
    assign rot_to_file = is_rlc && instr.word[RRO_DEST_BIT];

    // Read address is the raw 7-bit field; bank select is applied outside
    assign file_raddr = instr.word[RRO_FAW-1:0];
    assign rot_val = rot_left(file_rdata, carry);

    // Returns stall the fetch for the second cycle
    // Busy comes from state alone, so it never depends on the word
    assign busy = (state == RRO_ST_FLUSH);
    assign stack_pop = ret_any;

    // Sequencer: returns spend one extra flush cycle
    always_comb begin
        next_state = state;
        unique case (state)
            // Normal issue; only returns leave it
            RRO_ST_EXEC: begin
                if (ret_any) begin
                    next_state = RRO_ST_FLUSH;
                end
            end
            // Second cycle of a return; the fetched word is dropped
            RRO_ST_FLUSH: begin
                next_state = RRO_ST_EXEC;
            end
            // Dead cycle after reset, so the first word sees settled state
            RRO_ST_IDLE: begin
                next_state = RRO_ST_EXEC;
            end
            default: begin
                next_state = RRO_ST_EXEC; // Recover from illegal codes
            end
        endcase
    end

    // State register; reset lands in the idle dead cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= RRO_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Next PC: pop on return, else step on each one-cycle word
    // Pop wins over step; a word never asks for both
    always_comb begin
        next_pc = pc;
        if (ret_any) begin
            next_pc = stack_top_entry;
        end else if (pc_step) begin
            next_pc = pc + 13'h0001;
        end
    end

    // Program counter register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pc <= RRO_PC_RST;
        end else begin
            pc <= next_pc;
        end
    end

    // Next W: literal return or rotate with d clear
    // Interrupt return leaves W alone so the handler's context survives
    always_comb begin
        next_w_reg = w_reg;
        if (is_retl) begin
            next_w_reg = instr.word[RRO_DW-1:0];
        end else if (rot_to_w) begin
            next_w_reg = rot_val;
        end
    end

    // Working register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            w_reg <= RRO_W_RST;
        end else begin
            w_reg <= next_w_reg;
        end
    end

    // Next carry: only rotate touches a flag
    // Returns and no-ops hold it, as they affect no status
    always_comb begin
        next_carry = carry;
        if (is_rlc) begin
            next_carry = file_rdata[RRO_MSB_BIT];
        end
    end

    // Carry register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            carry <= RRO_CARRY_RST;
        end else begin
            carry <= next_carry;
        end
    end

    // Global enable set by interrupt return; clearing is the controller's job
    // Set only here, so no clear path can race it inside this block
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            global_irq_enable <= RRO_IRQ_EN_RST;
        end else if (is_reti) begin
            global_irq_enable <= 1'b1;
        end
    end

    // File write-back only when destination bit is set
    // Address and data follow every cycle; only the strobe qualifies them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            file_wr <= '0;
        end else begin
            file_wr.en <= rot_to_file;
            file_wr.addr <= instr.word[RRO_FAW-1:0];
            file_wr.data <= rot_val;
        end
    end
endmodule

// file: logic/rro_pkg.sv
// Purpose: Shared constants and carriers for the return/rotate opcode slice.
// Assumes: 14-bit instruction words, 8-bit data, 13-bit program counter.
// Notes: Opcode patterns are given as value and care mask.
package rro_pkg;
    localparam int RRO_IW = 14;
    localparam int RRO_DW = 8;
    localparam int RRO_PCW = 13;
    localparam int RRO_FAW = 7;
    // Opcode values and masks (mask bit 1 = bit compared)
    localparam logic [13:0] RRO_NO_OPERATION_VAL = 14'h0000;
    localparam logic [13:0] RRO_NO_OPERATION_MASK = 14'h3F9F;
    localparam logic [13:0] RRO_RETI_VAL = 14'h0009;
    localparam logic [13:0] RRO_RETI_MASK = 14'h3FFF;
    localparam logic [13:0] RRO_RETL_VAL = 14'h3400;
    localparam logic [13:0] RRO_RETL_MASK = 14'h3C00;
    localparam logic [13:0] RRO_RLC_VAL = 14'h0D00;
    localparam logic [13:0] RRO_RLC_MASK = 14'h3F00;
    // Field positions
    localparam int RRO_DEST_BIT = 7;
    localparam int RRO_MSB_BIT = 7;
    // Reset values
    localparam logic [12:0] RRO_PC_RST = 13'h0000;
    localparam logic [7:0] RRO_W_RST = 8'h00;
    localparam logic RRO_IRQ_EN_RST = 1'b0;
    localparam logic RRO_CARRY_RST = 1'b0;
    // Cycle counts
    localparam int RRO_RET_CYCLES = 2;
    localparam int RRO_ONE_CYCLE = 1;

    // One instruction presented to the block
    typedef struct packed {
        logic valid;
        logic [RRO_IW-1:0] word;
    } rro_instr_t;

    // File register write request
    typedef struct packed {
        logic en;
        logic [RRO_FAW-1:0] addr;
        logic [RRO_DW-1:0] data;
    } rro_fwrite_t;

    typedef enum logic [2:0] {
        RRO_ST_EXEC = 3'b001,
        RRO_ST_FLUSH = 3'b010,
        RRO_ST_IDLE = 3'b100
    } rro_state_t;
endpackage

// file: sim/rro_core_checker.sv
// Purpose: Port assertions for the return/rotate slice.
// Assumes: A word is taken when valid, not busy, not the dead cycle.
// Notes: rdy stands in for the dead cycle after reset.
`timescale 1ns/1ps
module rro_chk
    import rro_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire rro_instr_t instr,
    input wire logic [RRO_PCW-1:0] stack_top_entry,
    input wire logic [RRO_DW-1:0] file_rdata,
    input wire logic [RRO_FAW-1:0] file_raddr,
    input wire logic busy,
    input wire logic stack_pop,
    input wire logic [RRO_PCW-1:0] pc,
    input wire logic [RRO_DW-1:0] w_reg,
    input wire logic carry,
    input wire logic global_irq_enable,
    input wire rro_fwrite_t file_wr
);
    logic rdy;
    logic tk;
    logic [13:0] wd;
    // Ready one edge after release
    always_ff @(posedge clk) begin
        rdy <= !sys_rst;
    end
    // Decode of the taken word
    assign wd = instr.word;
    assign tk = instr.valid && !busy && rdy;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_flush; busy ##1 !busy; endsequence
    property p_reti; tk && wd == RRO_RETI_VAL |-> stack_pop ##1 busy && global_irq_enable
        && pc == $past(stack_top_entry) && carry == $past(carry); endproperty
    property p_retl; tk && (wd & RRO_RETL_MASK) == RRO_RETL_VAL |->
        ##1 w_reg == $past(wd[7:0]) && carry == $past(carry); endproperty
    property p_retpc; tk && (wd & RRO_RETL_MASK) == RRO_RETL_VAL |->
        stack_pop ##1 pc == $past(stack_top_entry) ##0 s_flush; endproperty
    property p_rlc; tk && (wd & RRO_RLC_MASK) == RRO_RLC_VAL |->
        ##1 carry == $past(file_rdata[7]) && !busy; endproperty
    property p_d0; tk && (wd & RRO_RLC_MASK) == RRO_RLC_VAL && !wd[7] |->
        ##1 w_reg == {$past(file_rdata[6:0]), $past(carry)} && !file_wr.en; endproperty
    property p_d1; tk && (wd & RRO_RLC_MASK) == RRO_RLC_VAL && wd[7] |-> ##1 file_wr.en
        && file_wr.data == {$past(file_rdata[6:0]), $past(carry)} && pc == $past(pc) + 13'h1;
    endproperty
    property p_addr; tk && (wd & RRO_RLC_MASK) == RRO_RLC_VAL |->
        file_raddr == wd[6:0] ##1 file_wr.addr == $past(wd[6:0]); endproperty
    property p_no_operation; tk && (wd & RRO_NO_OPERATION_MASK) == RRO_NO_OPERATION_VAL
        |-> !stack_pop ##1
        pc == $past(pc) + 13'h1 && w_reg == $past(w_reg) && !file_wr.en; endproperty
    a_reti: assert property (p_reti) else $error("interrupt return wrong");
    a_retl: assert property (p_retl) else $error("literal not in w");
    a_retpc: assert property (p_retpc) else $error("literal return pc or flush wrong");
    a_rlc: assert property (p_rlc) else $error("rotate carry wrong");
    a_d0: assert property (p_d0) else $error("rotate to w wrong");
    a_d1: assert property (p_d1) else $error("rotate to file wrong");
    a_addr: assert property (p_addr) else $error("file address wrong");
    a_no_operation: assert property (p_no_operation) else $error("no-op changed state");
endmodule
bind rro_core rro_chk u_chk(
    .clk(clk),
    .sys_rst(sys_rst),
    .instr(instr),
    .stack_top_entry(stack_top_entry),
    .file_rdata(file_rdata),
    .file_raddr(file_raddr),
    .busy(busy),
    .stack_pop(stack_pop),
    .pc(pc),
    .w_reg(w_reg),
    .carry(carry),
    .global_irq_enable(global_irq_enable),
    .file_wr(file_wr)
);

// file: sim/rro_core_tb.sv
// Purpose: Random run of no-op, returns and rotate-left.
// Assumes: One word per op; a return is followed by a refused word.
// Notes: Expected results queue up with their drive time.
`timescale 1ns/1ps
module rro_core_tb;
    import rro_pkg::*;
    logic clk = 0;
    logic sys_rst = 1;
    rro_instr_t instr = '0;
    logic [RRO_PCW-1:0] stack_top_entry = '0;
    logic [RRO_DW-1:0] file_rdata = '0;
    logic [RRO_FAW-1:0] file_raddr;
    logic busy, stack_pop, carry, global_irq_enable;
    logic [RRO_PCW-1:0] pc, m_pc = '0;
    logic [RRO_DW-1:0] w_reg, m_w = '0;
    logic m_c = 0, m_g = 0;
    rro_fwrite_t file_wr;
    int error_cnt = 0, total_checks = 0;
    logic [32:0] exp_q[$];
    time t_q[$];
    always #2 clk = ~clk;
    rro_core dut(
        .clk(clk),
        .sys_rst(sys_rst),
        .instr(instr),
        .stack_top_entry(stack_top_entry),
        .file_rdata(file_rdata),
        .file_raddr(file_raddr),
        .busy(busy),
        .stack_pop(stack_pop),
        .pc(pc),
        .w_reg(w_reg),
        .carry(carry),
        .global_irq_enable(global_irq_enable),
        .file_wr(file_wr)
    );
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Drive one word, update the model, and feed a refused word after returns
    task automatic op(input logic [13:0] wd);
        logic [7:0] fd = 8'($urandom);
        logic [12:0] st = 13'($urandom);
        logic r = (wd & RRO_RETL_MASK) == RRO_RETL_VAL || wd == RRO_RETI_VAL;
        logic fe = (wd & RRO_RLC_MASK) == RRO_RLC_VAL && wd[7];
        logic [7:0] rv = {fd[6:0], m_c};
        @(posedge clk);
        instr <= {1'b1, wd};
        file_rdata <= fd;
        stack_top_entry <= st;
        m_pc = r ? st : m_pc + 13'h1;
        m_g = m_g | (wd == RRO_RETI_VAL);
        if ((wd & RRO_RETL_MASK) == RRO_RETL_VAL) m_w = wd[7:0];
        if ((wd & RRO_RLC_MASK) == RRO_RLC_VAL) begin
            m_w = wd[7] ? m_w : rv;
            m_c = fd[7];
        end
        exp_q.push_back({m_pc, m_w, m_c, m_g, fe, fe ? rv : 8'h00, r});
        t_q.push_back($time);
        if (r) begin
            @(posedge clk);
            instr <= {1'b1, RRO_NO_OPERATION_VAL};
            stack_top_entry <= ~st;
        end
    endtask
    // Compare once the taking edge has landed
    always @(negedge clk) begin
        if (t_q.size() > 0 && $time > t_q[0] + 4) begin
            check({pc, w_reg, carry, global_irq_enable, file_wr.en,
                file_wr.en ? file_wr.data : 8'h00, busy}, exp_q.pop_front());
            void'(t_q.pop_front());
        end
    end
    initial begin
        logic [31:0] r = $urandom(32'hDA59F518);
        repeat (20) @(posedge clk);
        sys_rst <= 0;
        for (int k = 0; k < 90; k++) begin
            r = $urandom;
            case (r[1:0])
                2'h0: op({7'h00, r[3:2], 5'h00});
                2'h1: op(r[12] ? RRO_RETI_VAL : {4'hD, r[11:2]});
                default: op({6'h0D, r[2], r[9:3]});
            endcase
        end
        @(posedge clk);
        instr.valid <= 0;
        repeat (3) @(posedge clk);
        results();
    end
    // Cut a hang short
    initial begin
        #5000;
        error_cnt++;
        results();
    end
endmodule
